/* File: src/sadc_clk_div.sv */
// Converter clock enable generator.
// Assumes a free-running core clock; emits one-cycle enable pulses.
`timescale 1ns/1ps
`default_nettype none
module sadc_clk_div #(
    parameter int DIV_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic [1:0] divSel,
    input wire logic restart,
    // Enable out
    output logic tick
);
    logic [DIV_W-1:0] count_r;
    logic [DIV_W-1:0] last;

    assign last = DIV_W'((sadc_pkg::DIV_MAX >> divSel) - 1);
    assign tick = (count_r == last) && !restart;

    // Restart aligns the first converter cycle with the start write
    always_ff @(posedge core_clk) begin
        if (!rst_n || restart || count_r == last) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end
endmodule : sadc_clk_div
`default_nettype wire

/* File: src/sadc_ctl_if.sv */
// Link between the register front end and the conversion sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface sadc_ctl_if;
    logic startPulse;
    logic abortPulse;
    logic convTick;
    logic cmpAbove;
    logic busy;
    logic donePulse;
    logic sampleHold;
    logic [11:0] trialCode;
    logic [11:0] result;

    modport ctl (output startPulse, abortPulse, convTick, cmpAbove,
                 input busy, donePulse, sampleHold, trialCode, result);
    modport seq (input startPulse, abortPulse, convTick, cmpAbove,
                 output busy, donePulse, sampleHold, trialCode, result);
endinterface : sadc_ctl_if
`default_nettype wire

/* File: src/sadc_pkg.sv */
// Shared constants for the converter control block.
// Assumes a 32-bit APB bus, word-addressed registers, and a 10 MHz core clock.
package sadc_pkg;

    // ****************************************************************
    // Register indices; the byte address is four times the index
    // ****************************************************************
    localparam logic [9:0] IDX_OPTION = 10'h094;
    localparam logic [9:0] IDX_INTERRUPT_FLAG_REG = 10'h095;
    localparam logic [9:0] IDX_RES_LO = 10'h0aa;
    localparam logic [9:0] IDX_RES_HI = 10'h0ab;
    localparam logic [9:0] IDX_CHANNEL_SELECT_REG = 10'h0ae;
    localparam logic [9:0] IDX_AUXILIARY_CONTROL_ONE = 10'h0f8;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h100;
    localparam logic [9:0] IDX_EVT_ENABLE = 10'h101;
    localparam logic [9:0] IDX_EVT_CLEAR = 10'h102;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DIV_SEL_LSB = 2;
    localparam int DONE_BIT = 4;
    localparam int START_BIT = 4;
    localparam int CHAN_LSB = 4;
    localparam int RES_LO_LSB = 4;
    localparam int EVT_DONE = 0;
    localparam int EVT_ABORT = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic [3:0] CHAN_RST = 4'hf;
    localparam logic [1:0] EVT_RST = 2'h0;

    // ****************************************************************
    // Conversion timing in converter clock cycles
    // ****************************************************************
    localparam int RESULT_BITS = 12;
    localparam int CYC_PER_BIT = 2;
    localparam int CONV_CYCLES = 50;
    localparam int SAMPLE_CYCLES = CONV_CYCLES - RESULT_BITS * CYC_PER_BIT;
    localparam int DIV_MAX = 32;

    // ****************************************************************
    // Channel codes
    // ****************************************************************
    localparam logic [3:0] CH_LAST_EXT = 4'hb;
    localparam logic [3:0] CH_BANDGAP = 4'hc;
    localparam logic [3:0] CH_AMP_OUT = 4'he;
    localparam logic [3:0] CH_GROUND = 4'hf;

    typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_CONVERT} sadc_state_e;

endpackage : sadc_pkg

/* File: src/sadc_seq.sv */
// Successive-approximation conversion sequencer.
// Assumes convTick pulses once per converter clock and cmpAbove is synchronised.
`timescale 1ns/1ps
`default_nettype none
module sadc_seq (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control link
    sadc_ctl_if.seq link
);
    sadc_pkg::sadc_state_e state_r;
    logic [5:0] count_r;
    logic [3:0] bitIdx_r;
    logic phase_r;
    logic [11:0] sar_r;
    logic [11:0] result_r;
    logic done_r;

    assign link.busy = (state_r != sadc_pkg::SADC_IDLE);
    assign link.donePulse = done_r;
    assign link.trialCode = sar_r;
    assign link.result = result_r;
    assign link.sampleHold = (state_r == sadc_pkg::SADC_SAMPLE);

    // ****************************************************************
    // Sequence
    // ****************************************************************
    // sample phase then two cycles per bit
    always_ff @(posedge core_clk) begin
        done_r <= 1'b0;
        if (!rst_n || link.abortPulse) begin
            state_r <= sadc_pkg::SADC_IDLE;
            count_r <= '0;
            bitIdx_r <= '0;
            phase_r <= 1'b0;
            sar_r <= '0;
        end else if (link.startPulse) begin
            state_r <= sadc_pkg::SADC_SAMPLE;
            count_r <= '0;
            phase_r <= 1'b0;
            sar_r <= '0;
        end else if (link.convTick) begin
            unique case (state_r)
                sadc_pkg::SADC_IDLE: begin
                end
                sadc_pkg::SADC_SAMPLE: begin
                    count_r <= count_r + 1'b1;
                    if (count_r == 6'(sadc_pkg::SAMPLE_CYCLES - 1)) begin
                        state_r <= sadc_pkg::SADC_CONVERT;
                        bitIdx_r <= 4'(sadc_pkg::RESULT_BITS - 1);
                        sar_r <= 12'h800;
                    end
                end
                sadc_pkg::SADC_CONVERT: begin
                    phase_r <= !phase_r;
                    if (phase_r) begin
                        // Drop the trial bit when the input sits below it
                        sar_r[bitIdx_r] <= link.cmpAbove;
                        if (bitIdx_r == 4'h0) begin
                            state_r <= sadc_pkg::SADC_IDLE;
                            done_r <= 1'b1;
                        end else begin
                            bitIdx_r <= bitIdx_r - 1'b1;
                            sar_r[bitIdx_r - 1'b1] <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // result loads with the done pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_r <= '0;
        end else if (link.convTick && state_r == sadc_pkg::SADC_CONVERT && phase_r && bitIdx_r == 4'h0) begin
            result_r <= {sar_r[11:1], link.cmpAbove};
        end
    end
endmodule : sadc_seq
`default_nettype wire

/* File: src/sadc_top.sv */
// Converter control block: APB register file, clock divider, sequencer.
// Assumes an APB master on core_clk and an external comparator output pin.
// Summary of operation
// - divide select picks sysclk/32, /16, /8, /4
// - start bit launches; hardware clears it at end
// - software may clear start by writing zero
// - done flag sets; interrupt only when enabled
// - done clears by EFh write or new start
// - conversion lasts fifty converter clock cycles
// - result bits 11:4 high, 3:0 low upper nibble
// - channel code routes input, bandgap, amplifier, ground
// - result loads together with the done flag
`timescale 1ns/1ps
`default_nettype none
module sadc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Analog front end
    input wire logic cmpAbove,
    output logic sampleHold,
    output logic [11:0] dacCode,
    output logic [11:0] extInputSel,
    output logic bandgapSel,
    output logic amplifierOutSel,
    output logic groundSel,
    // Interrupt
    output logic irq
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    sadc_ctl_if link ();

    logic [7:0] option_r;
    logic [3:0] chanSel_r;
    logic convStart_r;
    logic convDoneFlag_r;
    logic [7:0] resHigh_r;
    logic [3:0] resLow_r;
    logic [1:0] divLatched_r;
    logic [3:0] chanLatched_r;
    logic [1:0] evtStatus_r;
    logic [1:0] evtEnable_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [2:0] cmpSync_r;
    logic cmpStable_r;
    logic [11:0] dacCode_r;
    logic sampleHold_r;
    logic [11:0] extSel_r;
    logic bandgapSel_r;
    logic ampSel_r;
    logic groundSel_r;
    logic irq_r;

    logic [9:0] idx;
    logic aligned;
    logic setupPh;
    logic wrEn;
    logic mapped;
    logic startWrite;
    logic stopWrite;
    logic [1:0] evtSet;
    logic [31:0] rdMux;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setupPh = psel && !penable;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite && pready && mapped;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r && psel && penable;

    always_comb begin
        mapped = 1'b0;
        if (aligned) begin
            unique case (idx)
                sadc_pkg::IDX_OPTION,
                sadc_pkg::IDX_INTERRUPT_FLAG_REG,
                sadc_pkg::IDX_RES_LO,
                sadc_pkg::IDX_RES_HI,
                sadc_pkg::IDX_CHANNEL_SELECT_REG,
                sadc_pkg::IDX_AUXILIARY_CONTROL_ONE,
                sadc_pkg::IDX_EVT_STATUS,
                sadc_pkg::IDX_EVT_ENABLE,
                sadc_pkg::IDX_EVT_CLEAR: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rdMux = 32'h0;
        unique case (idx)
            sadc_pkg::IDX_OPTION: rdMux[7:0] = option_r;
            sadc_pkg::IDX_INTERRUPT_FLAG_REG: rdMux[sadc_pkg::DONE_BIT] = convDoneFlag_r;
            sadc_pkg::IDX_RES_LO: rdMux[7:0] = {resLow_r, 4'h0};
            sadc_pkg::IDX_RES_HI: rdMux[7:0] = resHigh_r;
            sadc_pkg::IDX_CHANNEL_SELECT_REG: rdMux[7:0] = {chanSel_r, 4'h0};
            sadc_pkg::IDX_AUXILIARY_CONTROL_ONE: rdMux[sadc_pkg::START_BIT] = convStart_r;
            sadc_pkg::IDX_EVT_STATUS: rdMux[1:0] = evtStatus_r;
            sadc_pkg::IDX_EVT_ENABLE: rdMux[1:0] = evtEnable_r;
            default: rdMux = 32'h0;
        endcase
    end

    // Read data sampled in the setup cycle so prdata comes from a flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setupPh) begin
            prdata_r <= (mapped && !pwrite) ? rdMux : 32'h0;
            pslverr_r <= !mapped;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            option_r <= sadc_pkg::OPTION_RST;
        end else if (wrEn && idx == sadc_pkg::IDX_OPTION) begin
            option_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chanSel_r <= sadc_pkg::CHAN_RST;
        end else if (wrEn && idx == sadc_pkg::IDX_CHANNEL_SELECT_REG) begin
            chanSel_r <= pwdata[sadc_pkg::CHAN_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            evtEnable_r <= sadc_pkg::EVT_RST;
        end else if (wrEn && idx == sadc_pkg::IDX_EVT_ENABLE) begin
            evtEnable_r <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // Start bit
    // ****************************************************************
    assign startWrite = wrEn && idx == sadc_pkg::IDX_AUXILIARY_CONTROL_ONE && pwdata[sadc_pkg::START_BIT];
    assign stopWrite = wrEn && idx == sadc_pkg::IDX_AUXILIARY_CONTROL_ONE && !pwdata[sadc_pkg::START_BIT];

    assign link.startPulse = startWrite;
    // Idle zero writes raise no abort event
    // a zero write abandons a running conversion
    assign link.abortPulse = stopWrite && link.busy;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            convStart_r <= 1'b0;
        end else if (startWrite) begin
            // write of one launches; a fresh start beats the end
            convStart_r <= 1'b1;
        end else if (stopWrite) begin
            convStart_r <= 1'b0;
        end else if (link.donePulse) begin
            // hardware clears at end of conversion
            convStart_r <= 1'b0;
        end
    end

    // settings frozen for the whole conversion
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            divLatched_r <= sadc_pkg::OPTION_RST[sadc_pkg::DIV_SEL_LSB +: 2];
            chanLatched_r <= sadc_pkg::CHAN_RST;
        end else if (startWrite) begin
            divLatched_r <= option_r[sadc_pkg::DIV_SEL_LSB +: 2];
            chanLatched_r <= chanSel_r;
        end else if (!link.busy) begin
            chanLatched_r <= chanSel_r;
        end
    end

    // ****************************************************************
    // Done flag and result
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            convDoneFlag_r <= 1'b0;
        end else if (link.donePulse) begin
            // set at completion, wins over a same-cycle clear
            convDoneFlag_r <= 1'b1;
        end else if (startWrite) begin
            convDoneFlag_r <= 1'b0;
        end else if (wrEn && idx == sadc_pkg::IDX_INTERRUPT_FLAG_REG && !pwdata[sadc_pkg::DONE_BIT]) begin
            // write of EFh clears the flag
            convDoneFlag_r <= 1'b0;
        end
    end

    // result registers update with the done flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            resHigh_r <= 8'h00;
            resLow_r <= 4'h0;
        end else if (link.donePulse) begin
            // bits 11:4 high byte, 3:0 low nibble
            resHigh_r <= link.result[11:4];
            resLow_r <= link.result[3:0];
        end
    end

    // ****************************************************************
    // Event status and interrupt
    // ****************************************************************
    assign evtSet[sadc_pkg::EVT_DONE] = link.donePulse;
    assign evtSet[sadc_pkg::EVT_ABORT] = link.abortPulse;

    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            evtStatus_r <= sadc_pkg::EVT_RST;
        end else if (wrEn && idx == sadc_pkg::IDX_EVT_CLEAR) begin
            evtStatus_r <= (evtStatus_r & ~pwdata[1:0]) | evtSet;
        end else begin
            evtStatus_r <= evtStatus_r | evtSet;
        end
    end

    // Registered: one cycle late, but free of decode glitches
    // request raised only when enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evtStatus_r & evtEnable_r);
        end
    end
    assign irq = irq_r;

    // ****************************************************************
    // Comparator pin synchroniser
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmpSync_r <= 3'h0;
        end else begin
            cmpSync_r <= {cmpSync_r[1:0], cmpAbove};
        end
    end

    // Single-cycle spikes on the pin never reach the sequencer
    // Change accepted only once second and third stages agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmpStable_r <= 1'b0;
        end else if (cmpSync_r[1] == cmpSync_r[2]) begin
            cmpStable_r <= cmpSync_r[2];
        end
    end
    assign link.cmpAbove = cmpStable_r;

    // ****************************************************************
    // Converter clock and sequencer
    // ****************************************************************
    sadc_clk_div #(
        .DIV_W(5)
    ) u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .divSel(divLatched_r),
        .restart(startWrite),
        .tick(link.convTick)
    );

    sadc_seq u_seq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .link(link.seq)
    );

    // ****************************************************************
    // Analog-side outputs
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dacCode_r <= 12'h000;
            sampleHold_r <= 1'b0;
        end else begin
            dacCode_r <= link.trialCode;
            sampleHold_r <= link.sampleHold;
        end
    end
    assign dacCode = dacCode_r;
    assign sampleHold = sampleHold_r;

    // Driven from the latch so a write during a conversion cannot move the switches
    // channel code to one-hot switch enables; reserved code opens all
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            extSel_r <= 12'h000;
            bandgapSel_r <= 1'b0;
            ampSel_r <= 1'b0;
            groundSel_r <= 1'b0;
        end else begin
            extSel_r <= 12'h000;
            if (chanLatched_r <= sadc_pkg::CH_LAST_EXT) begin
                extSel_r[chanLatched_r] <= 1'b1;
            end
            bandgapSel_r <= (chanLatched_r == sadc_pkg::CH_BANDGAP);
            ampSel_r <= (chanLatched_r == sadc_pkg::CH_AMP_OUT);
            groundSel_r <= (chanLatched_r == sadc_pkg::CH_GROUND);
        end
    end
    assign extInputSel = extSel_r;
    assign bandgapSel = bandgapSel_r;
    assign amplifierOutSel = ampSel_r;
    assign groundSel = groundSel_r;

endmodule : sadc_top
`default_nettype wire

/* File: tb/sadc_checker.sv */
// Port checker for the converter control block.
// Assumes it is bound to sadc_top on core_clk.
`timescale 1ns/1ps
`default_nettype none
module sadc_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Front end and interrupt
    input wire logic sampleHold,
    input wire logic [11:0] extInputSel,
    input wire logic bandgapSel,
    input wire logic amplifierOutSel,
    input wire logic groundSel,
    input wire logic irq
);
    logic acc;
    logic [14:0] sel;
    assign acc = psel && penable;
    assign sel = {extInputSel, bandgapSel, amplifierOutSel, groundSel};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_sel_onehot: assert property ($onehot0(sel))
        else $error("more than one converter input routed");
    a_ground_rst: assert property ($rose(rst_n) |-> ##[1:2] groundSel)
        else $error("ground not routed after reset");
    a_sel_frozen: assert property (sampleHold && $past(sampleHold) |-> $stable(sel))
        else $error("input routing moved during sampling");
    a_sample_min: assert property ($rose(sampleHold) |-> sampleHold[*8])
        else $error("sample phase too short");
    a_start_sample: assert property (acc && pwrite && paddr == 12'h3e0 && pwdata[4] |-> ##[1:3] sampleHold)
        else $error("start did not begin sampling");
    a_abort_stop: assert property (acc && pwrite && paddr == 12'h3e0 && !pwdata[4] |-> ##[1:3] !sampleHold)
        else $error("abort left sampling running");
    a_irq_mask: assert property (acc && pwrite && paddr == 12'h404 && pwdata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("interrupt high while masked");
    a_lo_unused: assert property (acc && !pwrite && paddr == 12'h2a8 |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
        else $error("unused result bits not zero");
    a_err_unmapped: assert property (acc && paddr == 12'hffc |-> pslverr && pready && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule : sadc_checker
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes sadc_top; comparator held at one level per conversion.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst_n, psel, penable, pwrite, cmpAbove, pready, pslverr, lastErr;
    logic sampleHold, bandgapSel, amplifierOutSel, groundSel, irq;
    logic [11:0] paddr, dacCode, extInputSel;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ch;
    int n_errors = 0;
    int num_checks = 0;
    int n;
    sadc_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cmpAbove(cmpAbove), .sampleHold(sampleHold), .dacCode(dacCode), .extInputSel(extInputSel),
        .bandgapSel(bandgapSel), .amplifierOutSel(amplifierOutSel), .groundSel(groundSel), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic stop_on_hang;
        n_errors++;
        tally_and_finish();
    endtask : stop_on_hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One transfer; an idle cycle first so psel is never reassigned in one step
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) stop_on_hang();
    endtask : apb
    function automatic logic [14:0] route(input logic [3:0] c);
        route = 15'h0;
        if (c <= 4'hb) route[c + 3] = 1'b1;
        else if (c == 4'hc) route[2] = 1'b1;
        else if (c == 4'he) route[1] = 1'b1;
        else if (c == 4'hf) route[0] = 1'b1;
    endfunction : route
    function automatic logic [31:0] sels();
        sels = {17'h0, extInputSel, bandgapSel, amplifierOutSel, groundSel};
    endfunction : sels
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 2000) stop_on_hang();
    endtask : wait_irq
    task automatic convert(input logic [1:0] ds, input logic hi);
        cmpAbove <= hi;
        apb(1'b1, sadc_pkg::IDX_OPTION, {28'h0, ds, 2'h0});
        apb(1'b1, sadc_pkg::IDX_EVT_CLEAR, 32'h3);
        apb(1'b1, sadc_pkg::IDX_AUXILIARY_CONTROL_ONE, 32'h10);
        wait_irq();
        chk({20'h0, dacCode}, {20'h0, {12{hi}}});
        chk(32'(n >= 50 * (32 >> ds) && n <= 50 * (32 >> ds) + 4), 32'h1);
        apb(1'b0, sadc_pkg::IDX_RES_HI, 32'h0);
        chk(rd, {24'h0, {8{hi}}});
        apb(1'b0, sadc_pkg::IDX_RES_LO, 32'h0);
        chk(rd, {24'h0, {4{hi}}, 4'h0});
        apb(1'b0, sadc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h0);
        chk(rd & 32'h10, 32'h10);
        apb(1'b0, sadc_pkg::IDX_AUXILIARY_CONTROL_ONE, 32'h0);
        chk(rd & 32'h10, 32'h0);
    endtask : convert
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cmpAbove = 1'b0;
        rd = $urandom(80799);
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(sels(), 32'h1);
        apb(1'b0, sadc_pkg::IDX_OPTION, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, sadc_pkg::IDX_CHANNEL_SELECT_REG, 32'h0);
        chk(rd & 32'hf0, 32'hf0);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, sadc_pkg::IDX_CHANNEL_SELECT_REG, 32'(c) << 4);
            repeat (3) @(posedge core_clk);
            chk(sels(), {17'h0, route(4'(c))});
        end
        apb(1'b1, sadc_pkg::IDX_EVT_ENABLE, 32'h3);
        for (int d = 0; d < 4; d++) convert(2'(d), 1'($urandom));
        apb(1'b1, sadc_pkg::IDX_INTERRUPT_FLAG_REG, 32'hef);
        apb(1'b0, sadc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h0);
        chk(rd & 32'h10, 32'h0);
        // Done event still pending, so masking must drop the line
        apb(1'b1, sadc_pkg::IDX_EVT_ENABLE, 32'h0);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, sadc_pkg::IDX_EVT_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, sadc_pkg::IDX_EVT_ENABLE, 32'h3);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        ch = 4'($urandom % 12);
        apb(1'b1, sadc_pkg::IDX_CHANNEL_SELECT_REG, {24'h0, ch, 4'h0});
        convert(2'h1, 1'b0);
        apb(1'b1, sadc_pkg::IDX_AUXILIARY_CONTROL_ONE, 32'h10);
        apb(1'b0, sadc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h0);
        chk(rd & 32'h10, 32'h0);
        apb(1'b1, sadc_pkg::IDX_CHANNEL_SELECT_REG, 32'he0);
        repeat (3) @(posedge core_clk);
        chk(sels(), {17'h0, route(ch)});
        apb(1'b1, sadc_pkg::IDX_AUXILIARY_CONTROL_ONE, 32'h0);
        apb(1'b0, sadc_pkg::IDX_AUXILIARY_CONTROL_ONE, 32'h0);
        chk(rd & 32'h10, 32'h0);
        apb(1'b0, sadc_pkg::IDX_EVT_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        repeat (3) @(posedge core_clk);
        chk({sampleHold, 31'h0} | sels(), {17'h0, route(4'he)});
        apb(1'b0, 10'h3ff, 32'h0);
        chk({lastErr, rd[30:0]}, 32'h80000000);
        apb(1'b1, sadc_pkg::IDX_RES_HI, 32'h55);
        apb(1'b0, sadc_pkg::IDX_RES_HI, 32'h0);
        chk(rd, 32'h0);
        n = $urandom % 256;
        apb(1'b1, sadc_pkg::IDX_OPTION, 32'(n));
        apb(1'b0, sadc_pkg::IDX_OPTION, 32'h0);
        chk(rd, 32'(n));
        tally_and_finish();
    end
endmodule : tb_top
bind sadc_top sadc_checker chk_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sampleHold(sampleHold), .extInputSel(extInputSel), .bandgapSel(bandgapSel),
    .amplifierOutSel(amplifierOutSel), .groundSel(groundSel), .irq(irq));
`default_nettype wire
